// >>> core/dvm_host.sv
// Interconnect-side controller that issues DVM messages and answers the master's read channel.
`timescale 1ns/1ps

// What this block does
// - Issue DVM operation and Sync on snoop channel
// - Always accept DVM Complete on read channel
// - Listed transaction types per channel; other types are still taken but raise an error
// - Undeclared capabilities are false and absent
// - Stash translation needs stash and untranslated
// - Version 8.1 handles 8.1, 8, 7
// - Version 8 handles 8 and 7
// - Two wake-up signals mark interface activity
// - One trace signal on the snoop, read address and read data channels
// - Read loopback returns the address loopback
// - Connect and disconnect handshake with coherency
// - Transactions may use different translation schemes
// - Check bits travel with the data
// - Poison flags already corrupted byte groups
module dvm_host #(
  parameter bit dvm_v8_prop = 1'b0,
  parameter bit dvm_v81_prop = 1'b0,
  parameter bit qos_accept_prop = 1'b0,
  parameter bit wakeup_prop = 1'b0,
  parameter bit trace_prop = 1'b0,
  parameter bit loopback_prop = 1'b0,
  parameter bit coherency_prop = 1'b0,
  parameter bit check_prop = 1'b0,
  parameter bit poison_prop = 1'b0,
  parameter bit stash_prop = 1'b0,
  parameter bit untranslated_prop = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output dvm_host_pkg::ac_type ac,
  input wire logic acready,
  input wire dvm_host_pkg::ar_type ar,
  output logic arready,
  output dvm_host_pkg::r_type r,
  input wire logic rready,
  input wire dvm_host_pkg::aw_type aw,
  output logic awready,
  input wire logic master_wakeup,
  output logic ac_wakeup,
  input wire logic coh_req,
  output logic coh_ack,
  output logic [3:0] varqosaccept,
  output logic [3:0] vawqosaccept
);

  // Capability flags; an undeclared one stays false and removes its feature.
  localparam bit stash_translation_ok = stash_prop & untranslated_prop;
  // Highest DVM version this port may emit; newer versions cover older ones.
  // A command asking for a newer version than this is refused and flagged.
  localparam logic [1:0] max_version = dvm_v81_prop ? dvm_host_pkg::dvm_v81 :
                                       (dvm_v8_prop ? dvm_host_pkg::dvm_v8 : dvm_host_pkg::dvm_v7);

  dvm_host_pkg::state_type state; // Registered state of the whole block.
  dvm_host_pkg::state_type next_state; // Value that state takes at the next edge.

  logic bus_take; // Bus access completes at this edge.
  logic ac_done; // Snoop message handed over at this edge.
  logic ar_take; // Read address accepted at this edge.
  logic ar_legal; // Read address carries a permitted type.
  logic aw_legal; // Write address carries a permitted type.
  logic is_complete; // Read address is a DVM Complete.
  logic sync_sent; // A Sync message leaves at this edge.
  logic launch; // Software starts a message at this edge.
  logic [3:0] set_err; // Error events raised at this edge.
  logic [31:0] status_word; // Live status as software reads it.
  logic [31:0] feature_word; // Declared capabilities as software reads them.
  logic [31:0] msg_addr; // Snoop address for a new message.
  logic [1:0] req_version; // Version that software asks for.

  // Outputs come straight from the state flip-flops.
  // Registered outputs avoid paths from inputs straight to outputs.
  assign avs_readdata = state.readdata;
  assign avs_waitrequest = state.waitrequest;
  assign ac = state.ac;
  assign arready = state.arready;
  assign awready = state.awready;
  assign r = state.r;
  assign ac_wakeup = state.wakeup;
  assign coh_ack = state.coh_ack;
  assign varqosaccept = state.qos_read;
  assign vawqosaccept = state.qos_write;

  // Decode of the live channel traffic and the bus access.
  // This process reads inputs and registered state only.
  always_comb begin
    // An access finishes on the edge at which waitrequest already stands low.
    bus_take = (avs_read | avs_write) & ~state.waitrequest;
    // The message is handed over on the edge at which the master is ready.
    ac_done = state.ac.valid & acready;
    // A read address is taken only while the single response slot is free.
    ar_take = ar.valid & state.arready;
    // A Complete is known by its opcode alone.
    is_complete = ar.snoop == dvm_host_pkg::ar_snoop_dvm_complete;
    // ReadNoSnoop, ReadOnce and the three maintenance types, or a Complete.
    // Anything else is answered as well but raises the illegal-type error.
    case (ar.snoop)
      dvm_host_pkg::ar_snoop_plain: begin
        ar_legal = 1'b1;
      end
      dvm_host_pkg::ar_snoop_clean_shared, dvm_host_pkg::ar_snoop_clean_invalid,
      dvm_host_pkg::ar_snoop_make_invalid, dvm_host_pkg::ar_snoop_dvm_complete: begin
        ar_legal = 1'b1;
      end
      default: begin
        ar_legal = 1'b0;
      end
    endcase
    // WriteNoSnoop or WriteUnique on the plain code, WriteLineUnique on its own code.
    aw_legal = (aw.snoop == dvm_host_pkg::aw_snoop_plain) |
               ((aw.snoop == dvm_host_pkg::aw_snoop_line_unique) &
                (aw.domain != dvm_host_pkg::domain_non_shareable) &
                (aw.domain != dvm_host_pkg::domain_system));
    // Version field of a command word as software writes it.
    req_version = avs_writedata[dvm_host_pkg::cmd_ver_lo +: 2];
    // A send order while a message still waits is dropped, not queued,
    // because the snoop channel carries one message at a time.
    launch = bus_take & avs_write & (avs_address == dvm_host_pkg::reg_ctrl) & avs_writedata[0] & ~state.ac.valid;
    // Only a Sync that the master has taken is owed a Complete.
    sync_sent = ac_done & state.ac_cmd[dvm_host_pkg::cmd_sync_bit];
    // A Sync carries the Sync type code in its message-type field.
    msg_addr = state.ac_addr;
    if (state.ac_cmd[dvm_host_pkg::cmd_sync_bit]) begin
      msg_addr[dvm_host_pkg::dvm_type_lo +: 3] = dvm_host_pkg::dvm_type_sync;
    end
    // Error events; each one lands in its own sticky status bit.
    set_err = 4'h0;
    // An illegal read type is still answered, so the master never hangs.
    set_err[0] = ar_take & ~ar_legal;
    set_err[1] = aw.valid & state.awready & ~aw_legal;
    set_err[2] = ar_take & is_complete & (state.pending == 4'h0);
    set_err[3] = bus_take & avs_write & (avs_address == dvm_host_pkg::reg_ac_cmd) &
                 (req_version > max_version);
    // Status packs busy, the owed Sync count and the sticky errors.
    status_word = 32'h0;
    status_word[dvm_host_pkg::st_busy_bit] = state.ac.valid;
    status_word[dvm_host_pkg::st_pending_lo +: 4] = state.pending;
    status_word[dvm_host_pkg::st_err_ar_bit +: 4] = state.errors;
    // Declared capabilities, one bit each except stash, which shows only through stash translation, so software sees what is absent.
    feature_word = {21'h0, stash_translation_ok, untranslated_prop, poison_prop, check_prop, coherency_prop,
                    loopback_prop, trace_prop, wakeup_prop, qos_accept_prop, dvm_v81_prop, dvm_v8_prop};
  end

  // Next-state logic for the bus slave, the snoop issuer and the read responder.
  always_comb begin
    // By default every field keeps its value; branches change what they own.
    next_state = state;
    // Bus slave: drop waitrequest for one cycle, then raise it again.
    // Read data load in that cycle, so they stand while waitrequest is low.
    // Every access therefore costs exactly two cycles.
    if ((avs_read | avs_write) & state.waitrequest) begin
      next_state.waitrequest = 1'b0;
      case (avs_address)
        dvm_host_pkg::reg_ac_addr: begin
          next_state.readdata = state.ac_addr;
        end
        dvm_host_pkg::reg_ac_cmd: begin
          next_state.readdata = {24'h0, state.ac_cmd};
        end
        dvm_host_pkg::reg_status: begin
          next_state.readdata = status_word;
        end
        dvm_host_pkg::reg_complete_count: begin
          next_state.readdata = state.completes;
        end
        dvm_host_pkg::reg_qos: begin
          next_state.readdata = {24'h0, state.qos_write, state.qos_read};
        end
        dvm_host_pkg::reg_features: begin
          next_state.readdata = feature_word;
        end
        default: begin
          // Control and unmapped offsets read as zero.
          next_state.readdata = 32'h0;
        end
      endcase
    end else begin
      // Idle, or the access has just finished: stall the next one a cycle.
      next_state.waitrequest = 1'b1;
    end
    // Register writes take effect at the completing edge.
    // Status clears and send orders are handled below, as they touch other fields.
    if (bus_take & avs_write) begin
      case (avs_address)
        dvm_host_pkg::reg_ac_addr: begin
          // The full word becomes the address of the next message.
          next_state.ac_addr = avs_writedata;
        end
        dvm_host_pkg::reg_ac_cmd: begin
          // A version beyond the declared one is refused and leaves the command alone.
          if (req_version <= max_version) begin
            next_state.ac_cmd = avs_writedata[7:0];
          end
        end
        dvm_host_pkg::reg_qos: begin
          // QoS floors exist only when the capability is declared.
          if (qos_accept_prop) begin
            next_state.qos_read = avs_writedata[3:0];
            next_state.qos_write = avs_writedata[7:4];
          end
        end
        default: begin
          // Other offsets ignore the write; the last read data stay put.
          next_state.readdata = state.readdata;
        end
      endcase
    end
    // Sticky errors: writing one clears, a new event in that cycle wins.
    next_state.errors = state.errors;
    if (bus_take & avs_write & (avs_address == dvm_host_pkg::reg_status)) begin
      next_state.errors = state.errors & ~avs_writedata[dvm_host_pkg::st_err_ar_bit +: 4];
    end
    next_state.errors = next_state.errors | set_err;
    // Snoop issuer: one message at a time, held until the master takes it.
    // A launch copies the command fields at once, so a later command write
    // cannot change a message that is already on the channel.
    if (launch) begin
      next_state.ac.valid = 1'b1;
      next_state.ac.addr = msg_addr;
      next_state.ac.snoop = dvm_host_pkg::ac_snoop_dvm;
      next_state.ac.prot = state.ac_cmd[dvm_host_pkg::cmd_prot_lo +: 3];
      next_state.ac.trace = trace_prop & state.ac_cmd[dvm_host_pkg::cmd_trace_bit];
    end else if (ac_done) begin
      // Accepted: the channel falls idle and the payload means nothing.
      next_state.ac.valid = 1'b0;
    end
    // Outstanding Sync count: a Sync adds one, its Complete removes one.
    // A Sync and a Complete in one cycle cancel and leave the count alone.
    if (sync_sent & ~(ar_take & is_complete)) begin
      // Four bits wide: more than fifteen owed Syncs would wrap the count.
      next_state.pending = state.pending + 4'h1;
    end else if (~sync_sent & ar_take & is_complete & (state.pending != 4'h0)) begin
      // A Complete with nothing owed leaves the owed count at zero and raises its error.
      next_state.pending = state.pending - 4'h1;
    end
    // Every DVM Complete is accepted and counted.
    if (ar_take & is_complete) begin
      // Spurious ones count too, so software sees every Complete.
      next_state.completes = state.completes + 32'h1;
    end
    // Read responder: one beat per address, address channel closed while it waits.
    // Only one beat is ever in flight, so no queue is needed.
    if (ar_take) begin
      // Close the address channel until the master has taken the beat.
      next_state.arready = 1'b0;
      next_state.r.valid = 1'b1;
      next_state.r.id = ar.id;
      // A plain read returns its own address; a Complete returns zero.
      next_state.r.data = is_complete ? 32'h0 : ar.addr;
      next_state.r.resp = dvm_host_pkg::rresp_okay;
      next_state.r.last = 1'b1;
      next_state.r.loop = loopback_prop ? ar.loop : 8'h0;
      next_state.r.trace = trace_prop & ar.trace;
      // Nothing here is known to be corrupt, so poison never rises.
      next_state.r.poison = 1'b0;
      // Odd parity over each data byte as check bits.
      for (int i = 0; i < 4; i++) begin
        next_state.r.datachk[i] = check_prop & ~(^(is_complete ? 8'h00 : ar.addr[8*i +: 8]));
      end
    end else if (state.r.valid & rready) begin
      // The beat is taken: drop it and reopen the address channel.
      next_state.r.valid = 1'b0;
      next_state.arready = 1'b1;
    end
    // Wake-up while a message is pending or the master signals activity.
    // The next snoop valid raises wake-up together with the message.
    next_state.wakeup = wakeup_prop & (next_state.ac.valid | master_wakeup);
    // Coherency connection acknowledge follows the request.
    // Without the capability the acknowledge stays low.
    next_state.coh_ack = coherency_prop & coh_req;
  end

  // State register with synchronous reset.
  // Reset clears everything, then sets the fields whose idle value is high.
  always_ff @(posedge clk) begin
    if (rst) begin
      // Both valids fall, so no message or beat survives a reset.
      state <= '0;
      // The bus stalls and both address channels stand open.
      state.waitrequest <= 1'b1;
      state.arready <= 1'b1;
      state.awready <= 1'b1;
      state.qos_read <= dvm_host_pkg::qos_reset;
      state.qos_write <= dvm_host_pkg::qos_reset;
    end else begin
      // Every register runs on every edge; there is no enable.
      state <= next_state;
    end
  end

  // Untranslated traffic needs no per-transaction handling here; any scheme is accepted.
  // Stash translation is only reported, since this port forwards no stashes.
endmodule

// >>> core/dvm_host_pkg.sv
// Shared constants, field layouts and carrier types for the DVM-issuing interconnect port.
package dvm_host_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] reg_ctrl = 5'h00;
  localparam logic [4:0] reg_ac_addr = 5'h04;
  localparam logic [4:0] reg_ac_cmd = 5'h08;
  localparam logic [4:0] reg_status = 5'h0C;
  localparam logic [4:0] reg_complete_count = 5'h10;
  localparam logic [4:0] reg_qos = 5'h14;
  localparam logic [4:0] reg_features = 5'h18;
  // Command register fields.
  localparam int cmd_sync_bit = 0;
  localparam int cmd_ver_lo = 2;
  localparam int cmd_prot_lo = 4;
  localparam int cmd_trace_bit = 7;
  // Status register fields: busy and owed Sync count, with the sticky error bits above them.
  localparam int st_busy_bit = 0;
  localparam int st_pending_lo = 4;
  localparam int st_err_ar_bit = 8;
  localparam int st_err_aw_bit = 9;
  localparam int st_err_spurious_bit = 10;
  localparam int st_err_version_bit = 11;
  // DVM message versions as software encodes them.
  localparam logic [1:0] dvm_v7 = 2'h0;
  localparam logic [1:0] dvm_v8 = 2'h1;
  localparam logic [1:0] dvm_v81 = 2'h2;
  // Snoop-channel, read-channel and write-channel opcodes.
  localparam logic [3:0] ac_snoop_dvm = 4'hF;
  localparam logic [3:0] ar_snoop_plain = 4'h0;
  localparam logic [3:0] ar_snoop_clean_shared = 4'h8;
  localparam logic [3:0] ar_snoop_clean_invalid = 4'h9;
  localparam logic [3:0] ar_snoop_make_invalid = 4'hD;
  localparam logic [3:0] ar_snoop_dvm_complete = 4'hE;
  localparam logic [2:0] aw_snoop_plain = 3'h0;
  localparam logic [2:0] aw_snoop_line_unique = 3'h1;
  // DVM message type field inside the snoop address, and the Sync code.
  localparam int dvm_type_lo = 12;
  localparam logic [2:0] dvm_type_sync = 3'h4;
  localparam logic [1:0] domain_non_shareable = 2'h0;
  localparam logic [1:0] domain_system = 2'h3;
  localparam logic [1:0] rresp_okay = 2'h0;
  localparam logic [3:0] qos_reset = 4'h0;
  // Snoop address channel driven towards the master.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [3:0] snoop;
    logic [2:0] prot;
    logic trace;
  } ac_type;
  // Read address channel arriving from the master.
  typedef struct packed {
    logic valid;
    logic [3:0] id;
    logic [31:0] addr;
    logic [3:0] snoop;
    logic [1:0] domain;
    logic [7:0] loop;
    logic trace;
  } ar_type;
  // Read data channel returned to the master.
  typedef struct packed {
    logic valid;
    logic [3:0] id;
    logic [31:0] data;
    logic [3:0] datachk;
    logic poison;
    logic [1:0] resp;
    logic last;
    logic [7:0] loop;
    logic trace;
  } r_type;
  // Write address channel arriving from the master (type check only).
  typedef struct packed {
    logic valid;
    logic [2:0] snoop;
    logic [1:0] domain;
  } aw_type;
  // Whole state of the controller.
  typedef struct packed {
    ac_type ac;
    logic arready;
    logic awready;
    r_type r;
    logic waitrequest;
    logic [31:0] readdata;
    logic [31:0] ac_addr;
    logic [7:0] ac_cmd;
    logic [3:0] pending;
    logic [3:0] errors;
    logic [31:0] completes;
    logic [3:0] qos_read;
    logic [3:0] qos_write;
    logic wakeup;
    logic coh_ack;
  } state_type;
endpackage

// >>> test/dvm_host_bench.sv
// Self-checking bench for the DVM host controller.
`timescale 1ns/1ps
module dvm_host_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd_data, q, a;
  logic avs_waitrequest, acready, arready, rready, awready, ac_wakeup, coh_ack, rd_done;
  dvm_host_pkg::ac_type ac;
  dvm_host_pkg::ar_type ar;
  dvm_host_pkg::r_type r;
  dvm_host_pkg::ar_type rd_req = '0;
  dvm_host_pkg::aw_type aw = '0;
  logic slow = 1'b0;
  logic rd_go = 1'b0;
  logic master_wakeup = 1'b0;
  logic coh_req = 1'b0;
  logic [3:0] varqosaccept, vawqosaccept;
  logic [7:0] rd_loop, c;
  logic [3:0] codes [4] = '{4'h0, 4'h8, 4'h9, 4'hD}; // Legal read-channel types.
  int syncs, n, err_count = 0, num_checks = 0, seed = 21, exp_syncs = 0;
  // Free-running 250 MHz clock.
  always #2 clk = ~clk;
  dvm_host #(.dvm_v8_prop(1'b1), .qos_accept_prop(1'b1), .trace_prop(1'b1),
    .loopback_prop(1'b1), .coherency_prop(1'b1)) dut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ac(ac), .acready(acready), .ar(ar), .arready(arready), .r(r), .rready(rready), .aw(aw),
    .awready(awready), .master_wakeup(master_wakeup), .ac_wakeup(ac_wakeup), .coh_req(coh_req),
    .coh_ack(coh_ack), .varqosaccept(varqosaccept), .vawqosaccept(vawqosaccept));
  dvm_master_model partner (.clk(clk), .rst(rst), .slow(slow), .ac(ac), .acready(acready), .ar(ar),
    .arready(arready), .r(r), .rready(rready), .rd_go(rd_go), .rd_req(rd_req), .rd_done(rd_done),
    .rd_data(rd_data), .rd_loop(rd_loop), .syncs(syncs));
  // Compares one value and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low; read data lands in q.
  task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k == 100) err_count++;
  endtask
  // Reads status and checks the sticky error field, then clears it.
  task automatic errs(input logic [3:0] exp);
    bus(1'b0, dvm_host_pkg::reg_status, 32'h0);
    check(q[11:8], exp);
    bus(1'b1, dvm_host_pkg::reg_status, 32'hF00);
  endtask
  // Has the master model issue one read-channel request and waits for its data.
  task automatic rd(input logic [3:0] sn, input logic [31:0] ad, input logic [7:0] lp);
    @(posedge clk);
    rd_req <= '{valid:1'b1, id:4'h3, addr:ad, snoop:sn, domain:2'h1, loop:lp, trace:1'b1};
    rd_go <= 1'b1;
    @(posedge clk);
    rd_go <= 1'b0;
    n = 0;
    while (rd_done !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) err_count++;
  endtask
  // Offers one write address for one cycle; awready is always high.
  task automatic aww(input logic [2:0] sn, input logic [1:0] dm);
    @(posedge clk);
    aw <= '{valid:1'b1, snoop:sn, domain:dm};
    @(posedge clk);
    aw <= ~aw;
  endtask
  // Expected snoop address: the Sync type code replaces bits 14:12.
  function automatic logic [31:0] exp_addr(input logic [31:0] ad, input logic s);
    exp_addr = ad;
    if (s) exp_addr[14:12] = dvm_host_pkg::dvm_type_sync;
  endfunction
  // Prints counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({avs_waitrequest, arready, awready, ac.valid}, 4'hE);
    bus(1'b1, dvm_host_pkg::reg_qos, 32'hA5);
    bus(1'b0, dvm_host_pkg::reg_qos, 32'h0);
    check({q[7:0], vawqosaccept, varqosaccept}, 16'hA5A5);
    bus(1'b1, 5'h1C, 32'hFFFF);
    bus(1'b0, 5'h1C, 32'h0);
    check(q, 32'h0);
    bus(1'b0, dvm_host_pkg::reg_features, 32'h0);
    check(q, 32'h75);
    for (int i = 0; i < 16; i++) begin
      a = $random(seed) & 32'hFFFF8FFF;
      c = 8'($random(seed));
      c[3] = 1'b0;
      slow <= c[1];
      c[1] = 1'b0;
      master_wakeup <= a[1];
      coh_req <= a[2];
      exp_syncs += c[0];
      bus(1'b1, dvm_host_pkg::reg_ac_addr, a);
      bus(1'b1, dvm_host_pkg::reg_ac_cmd, {24'h0, c});
      bus(1'b1, dvm_host_pkg::reg_ctrl, 32'h1);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (ac.valid !== 1'b1 && n < 20);
      if (n == 20) err_count++;
      check(ac.addr, exp_addr(a, c[0]));
      check({ac.trace, ac.prot}, c[7:4]);
      check(ac_wakeup, 1'b0);
      check(coh_ack, a[2]);
      n = 0;
      do begin
        bus(1'b0, dvm_host_pkg::reg_status, 32'h0);
        n++;
      end while (q[dvm_host_pkg::st_busy_bit] !== 1'b0 && n < 50);
    end
    n = 0;
    do begin
      bus(1'b0, dvm_host_pkg::reg_complete_count, 32'h0);
      n++;
    end while (q !== exp_syncs && n < 50);
    check(q, exp_syncs);
    check(syncs, exp_syncs);
    errs(4'h0);
    bus(1'b1, dvm_host_pkg::reg_ac_cmd, {28'h0, dvm_host_pkg::dvm_v81, 2'h0});
    errs(4'h8);
    errs(4'h0);
    for (int i = 0; i < 4; i++) begin
      a = $random(seed);
      c = 8'($random(seed));
      rd(codes[i], a, c);
      check({rd_data, rd_loop}, {a, c});
    end
    errs(4'h0);
    rd(4'h1, a, c);
    errs(4'h1);
    rd(dvm_host_pkg::ar_snoop_dvm_complete, 32'h0, 8'h0);
    errs(4'h4);
    aww(dvm_host_pkg::aw_snoop_plain, dvm_host_pkg::domain_non_shareable);
    aww(dvm_host_pkg::aw_snoop_line_unique, 2'h2);
    errs(4'h0);
    aww(dvm_host_pkg::aw_snoop_line_unique, dvm_host_pkg::domain_non_shareable);
    errs(4'h2);
    aww(3'h5, dvm_host_pkg::domain_system);
    errs(4'h2);
    complete_run();
  end
endmodule

// >>> test/dvm_host_properties.sv
// Concurrent checks on the ports of the DVM host controller.
`timescale 1ns/1ps
module dvm_host_properties #(
  parameter bit coherency_prop = 1'b0,
  parameter bit loopback_prop = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire dvm_host_pkg::ac_type ac,
  input wire logic acready,
  input wire dvm_host_pkg::ar_type ar,
  input wire logic arready,
  input wire dvm_host_pkg::r_type r,
  input wire logic rready,
  input wire logic coh_req,
  input wire logic coh_ack
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_AR_TO_R: assert property (ar.valid && arready |=> r.valid && r.id == $past(ar.id))
    else $error("read data missing after address accept");
  AST_R_DATA: assert property (ar.valid && arready |=>
    r.data == (($past(ar.snoop) == dvm_host_pkg::ar_snoop_dvm_complete) ? 32'h0 : $past(ar.addr)))
    else $error("read data does not match the request");
  AST_R_LOOP: assert property (loopback_prop && ar.valid && arready |=> r.loop == $past(ar.loop))
    else $error("loopback value not echoed");
  AST_R_HOLD: assert property (r.valid && !rready |=> $stable(r))
    else $error("read data changed before it was taken");
  AST_R_SHAPE: assert property (r.valid |-> !arready && r.last && !r.poison && r.resp == dvm_host_pkg::rresp_okay)
    else $error("read beat malformed or address still open");
  AST_R_DONE: assert property (r.valid && rready |=> !r.valid && arready)
    else $error("read channel not reopened after data");
  AST_AC_HOLD: assert property (ac.valid && !acready |=> ac.valid && $stable(ac))
    else $error("snoop message dropped or changed while stalled");
  AST_AC_TYPE: assert property (ac.valid |-> ac.snoop == dvm_host_pkg::ac_snoop_dvm)
    else $error("snoop channel carries a non-DVM type");
  AST_AC_DONE: assert property (ac.valid && acready |=> !ac.valid)
    else $error("snoop message repeated after acceptance");
  AST_COH_ACK: assert property (!$past(rst) |-> coh_ack == (coherency_prop && $past(coh_req)))
    else $error("coherency acknowledge does not follow its request");
endmodule

bind dvm_host dvm_host_properties #(.coherency_prop(coherency_prop), .loopback_prop(loopback_prop)) u_props (
  .clk(clk), .rst(rst), .ac(ac), .acready(acready), .ar(ar), .arready(arready), .r(r), .rready(rready),
  .coh_req(coh_req), .coh_ack(coh_ack));

// >>> test/dvm_master_model.sv
// Model of the IO-coherent master: takes snoop messages and answers each Sync with a Complete.
`timescale 1ns/1ps
module dvm_master_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire dvm_host_pkg::ac_type ac,
  output logic acready,
  output dvm_host_pkg::ar_type ar,
  input wire logic arready,
  input wire dvm_host_pkg::r_type r,
  output logic rready,
  input wire logic rd_go,
  input wire dvm_host_pkg::ar_type rd_req,
  output logic rd_done,
  output logic [31:0] rd_data,
  output logic [7:0] rd_loop,
  output int syncs
);
  int owed; // Syncs still owed a Complete.
  logic tick; // Stalls every other cycle in slow mode.
  // One Complete per Sync, sent only after the earlier message was taken; reads fill idle slots.
  always @(posedge clk) begin
    if (rst) begin
      acready <= 1'b0;
      ar <= '0;
      rready <= 1'b0;
      rd_done <= 1'b0;
      owed = 0;
      syncs <= 0;
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      acready <= ~(slow & tick);
      rready <= ~(slow & tick);
      rd_done <= r.valid && rready;
      if (r.valid && rready) begin
        rd_data <= r.data;
        rd_loop <= r.loop;
      end
      // Every message version is taken alike.
      if (ac.valid && acready && ac.addr[14:12] == dvm_host_pkg::dvm_type_sync) begin
        owed = owed + 1;
        syncs <= syncs + 1;
      end
      // A released address channel shows inverted leftovers, valid low.
      if (ar.valid && arready) begin
        ar <= ~ar;
      end else if (!ar.valid && !r.valid && owed > 0) begin
        ar <= '{valid:1'b1, id:4'h0, addr:32'h0, snoop:dvm_host_pkg::ar_snoop_dvm_complete,
                domain:2'h1, loop:8'h0, trace:1'b0};
        owed = owed - 1;
      end else if (!ar.valid && !r.valid && rd_go) begin
        ar <= rd_req;
      end
    end
  end
endmodule
